// file: src/fps_sequencer.v
// Operation
// R1: On each start, step setpoint zero to limit in 15 steps over soft-start.
// R2: During soft-start either soft-start or feedback comparator ends on-time.
// R3: Ignore current-sense comparator for 250 ns after each on-time start.
// R4: Drive off at feedback/5 trip; limit comparator caps at 0.7 V.
// R5: Sense at 1.5 times limit enters protection at once.
// R6: Setpoint at limit runs fault timer; timeout latches or autorecovers.
// R7: Fault timer clears when setpoint falls back below limit early.
// R8: Maximum on-time termination also runs the fault timer.
// R9: Supply under turn-off level 10 us enters same recoverable latch.
// R10: External latch request or supply overvoltage latches off, no autorecovery.
// R11: Thermal shutdown 10 us stops switching and start-up source.
// R12: Feedback below off level 150 ms stops, internal supply off.
// R13: Autorecovery resumes if fault gone, else another burst.
// R14: Switching only while latch pin lies inside its window.
// R15: Latch pin crossings shorter than 50/350 us are blanked.
// R16: Latched-off clears only on brown-out or supply reset.
// R17: Latch pin ignored until turn-on; low side only after soft-start.
// R18: Boosted thermistor bias only during soft-start.
// R19: Sawtooth slope subtracted from scaled feedback setpoint, per variant.
// R20: Overpower compensation only while feedback above enable level.
// R21: 3 bit peak conversion sampled and reset on unplug detector events.
// R22: Peak sample valid only after two quiet sample clocks.
// R23: Synchronize all comparator inputs before use.
`timescale 1ns/1ns
`include "fps_consts.vh"
module fps_sequencer #(
    parameter AUTORECOVER = 0,
    parameter FAST_VARIANT = 0,
    parameter SS_CYCLES = `FPS_SS_CYC,
    parameter FAULT_CYCLES = `FPS_FAULT_CYC,
    parameter AUTOREC_CYCLES = `FPS_AUTOREC_CYC,
    parameter OFF_CYCLES = `FPS_OFF_CYC,
    parameter LATCH_LO_CYCLES = `FPS_LATCH_LO_CYC
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire osc_pulse,
    input wire supply_on,
    input wire supply_under_off,
    input wire supply_reset,
    input wire supply_over,
    input wire line_ok,
    input wire thermal_shutdown,
    input wire feedback_trip,
    input wire soft_start_trip,
    input wire limit_trip,
    input wire winding_short_trip,
    input wire max_on_time,
    input wire external_latch,
    input wire feedback_below_off,
    input wire feedback_above_on,
    input wire feedback_above_opc,
    input wire latch_pin_high,
    input wire latch_pin_low,
    input wire [2:0] peak_code,
    input wire peak_sample_evt,
    input wire line_edge,
    input wire line_fall,
    output reg gate_drive_output,
    output reg [3:0] setpoint_step,
    output reg slope_enable,
    output reg slope_fast,
    output reg boosted_thermistor_bias,
    output reg opc_enable,
    output reg [2:0] peak_value,
    output reg peak_valid,
    output reg peak_reset,
    output reg startup_source_en,
    output reg internal_supply_en,
    output reg latched_off,
    output reg fault_active
);
    localparam CW = 32;
    localparam [CW-1:0] SS_STEP_CYC = SS_CYCLES / `FPS_SS_STEPS;
    localparam [CW-1:0] LEB_CYC = `FPS_LEB_CYC;
    localparam [CW-1:0] SUP_CYC = `FPS_SUPPLY_FILT_CYC;
    localparam [CW-1:0] EXT_CYC = FAST_VARIANT ? `FPS_EXT_FILT_FAST_CYC :
        `FPS_EXT_FILT_SLOW_CYC;
    localparam [CW-1:0] HI_CYC = `FPS_LATCH_HI_CYC;
    localparam integer STEPS = `FPS_SS_STEPS;
    localparam [3:0] STEP_MAX = STEPS[3:0];

    // Two-stage synchronisers; only stage two is read
    localparam NS = 19;
    wire [NS-1:0] raw_in = {supply_on, supply_under_off, supply_reset,
        supply_over, line_ok, thermal_shutdown, feedback_trip,
        soft_start_trip, limit_trip, winding_short_trip, max_on_time,
        external_latch, feedback_below_off, feedback_above_on,
        feedback_above_opc, latch_pin_high, latch_pin_low, line_edge,
        line_fall};
    reg [NS-1:0] sync_a;
    reg [NS-1:0] sync_b;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_a <= {NS{1'b0}};
            sync_b <= {NS{1'b0}};
        end else begin
            sync_a <= raw_in; // see R23
            sync_b <= sync_a; // see R23
        end
    end
    wire s_on = sync_b[18];
    wire s_uvlo = sync_b[17];
    wire s_vrst = sync_b[16];
    wire s_ovp = sync_b[15];
    wire s_line = sync_b[14];
    wire s_tsd = sync_b[13];
    wire s_fb = sync_b[12];
    wire s_ss = sync_b[11];
    wire s_lim = sync_b[10];
    wire s_short = sync_b[9];
    wire s_maxon = sync_b[8];
    wire s_ext = sync_b[7];
    wire s_fboff = sync_b[6];
    wire s_fbon = sync_b[5];
    wire s_opc = sync_b[4];
    wire s_lhi = sync_b[3];
    wire s_llo = sync_b[2];
    wire s_ledge = sync_b[1];
    wire s_lfall = sync_b[0];

    reg [2:0] state;
    reg [2:0] next_state;
    reg [CW-1:0] ss_cnt;
    reg [CW-1:0] fault_cnt;
    reg [CW-1:0] rec_cnt;
    reg [CW-1:0] leb_cnt;
    reg hard_latch;
    reg fault_run;

    // Brown-out or supply reset is the only path out of the hard latch; the recovery state also leaves on its timer
    wire release_all = !s_line || s_vrst; // see R16
    wire running = (state == `FPS_ST_SOFT) || (state == `FPS_ST_RUN);
    wire soft_done = (state == `FPS_ST_RUN);

    wire uv_done, ov_done, tsd_done, ext_done, off_done, hi_done, lo_done;
    fps_filter #(.WIDTH(CW)) u_uv (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(!running), .level(s_uvlo), .limit(SUP_CYC),
        .done(uv_done)); // see R9
    fps_filter #(.WIDTH(CW)) u_ov (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(1'b0), .level(s_ovp), .limit(SUP_CYC),
        .done(ov_done)); // see R10
    fps_filter #(.WIDTH(CW)) u_tsd (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(1'b0), .level(s_tsd), .limit(SUP_CYC),
        .done(tsd_done)); // see R11
    fps_filter #(.WIDTH(CW)) u_ext (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(1'b0), .level(s_ext), .limit(EXT_CYC),
        .done(ext_done)); // see R10
    fps_filter #(.WIDTH(CW)) u_off (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(!running), .level(s_fboff), .limit(OFF_CYCLES),
        .done(off_done)); // see R12
    // High side is watched from turn-on, low side only after soft-start
    fps_filter #(.WIDTH(CW)) u_lhi (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(!s_on && !running), .level(s_lhi), .limit(HI_CYC),
        .done(hi_done)); // see R15, R17
    fps_filter #(.WIDTH(CW)) u_llo (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clear(!soft_done), .level(s_llo), .limit(LATCH_LO_CYCLES),
        .done(lo_done)); // see R15, R17

    wire hard_trip = ext_done || ov_done || hi_done || lo_done; // see R10, R14
    wire fault_out = (fault_cnt >= FAULT_CYCLES - 1) && fault_run;
    wire soft_trip = s_short || uv_done || fault_out; // see R5, R9, R6
    wire can_start = s_on && s_line && !s_tsd && !hard_latch && !s_lhi;

    always @* begin
        next_state = state;
        case (state)
            `FPS_ST_IDLE: begin
                if (can_start)
                    next_state = `FPS_ST_SOFT; // see R1, R17
            end
            `FPS_ST_SOFT, `FPS_ST_RUN: begin
                if (hard_trip || soft_trip)
                    next_state = (AUTORECOVER && !hard_trip) ?
                        `FPS_ST_REC : `FPS_ST_LATCH; // see R6, R10
                else if (tsd_done || off_done || !s_line)
                    next_state = `FPS_ST_STOP; // see R11, R12
                else if (state == `FPS_ST_SOFT &&
                         ss_cnt >= SS_CYCLES - 1)
                    next_state = `FPS_ST_RUN;
            end
            `FPS_ST_LATCH: begin
                if (release_all)
                    next_state = `FPS_ST_STOP; // see R16
            end
            `FPS_ST_REC: begin
                if (release_all)
                    next_state = `FPS_ST_STOP;
                else if (rec_cnt >= AUTOREC_CYCLES - 1)
                    next_state = `FPS_ST_IDLE; // see R13
            end
            `FPS_ST_STOP: begin
                if (s_on && s_line && !s_tsd && !s_fboff &&
                    (s_fbon || !off_done))
                    next_state = `FPS_ST_IDLE; // see R11, R12
            end
            default: next_state = `FPS_ST_IDLE;
        endcase
    end

    // Pulse terminates on the feedback or limit comparator, on the soft-start comparator during soft-start only, or on maximum on-time
    wire cs_seen = leb_cnt >= LEB_CYC; // see R3
    wire end_on = cs_seen && (s_fb || s_lim ||
        (state == `FPS_ST_SOFT && s_ss)); // see R2, R4
    wire at_limit = s_lim || (state == `FPS_ST_SOFT &&
        setpoint_step == STEP_MAX && !s_fb);

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= `FPS_ST_IDLE;
            ss_cnt <= {CW{1'b0}};
            fault_cnt <= {CW{1'b0}};
            rec_cnt <= {CW{1'b0}};
            leb_cnt <= {CW{1'b0}};
            fault_run <= 1'b0;
            hard_latch <= 1'b0;
            gate_drive_output <= 1'b0;
            setpoint_step <= 4'h0;
        end else begin
            state <= next_state;
            if (hard_trip && running)
                hard_latch <= 1'b1;
            else if (release_all)
                hard_latch <= 1'b0; // see R16
            if (next_state == `FPS_ST_SOFT && state != `FPS_ST_SOFT) begin
                ss_cnt <= {CW{1'b0}};
                setpoint_step <= 4'h0;
            end else if (state == `FPS_ST_SOFT) begin
                ss_cnt <= ss_cnt + 1'b1;
                if (ss_cnt != 0 && ss_cnt % SS_STEP_CYC == 0 &&
                    setpoint_step < STEP_MAX)
                    setpoint_step <= setpoint_step + 1'b1; // see R1
            end else if (state == `FPS_ST_RUN) begin
                setpoint_step <= STEP_MAX;
            end else begin
                setpoint_step <= 4'h0;
            end
            // Count first so that a clear below takes priority
            if (running && fault_run)
                fault_cnt <= fault_cnt + 1'b1;
            if (!running) begin
                fault_run <= 1'b0;
                fault_cnt <= {CW{1'b0}};
            end else if (gate_drive_output && s_maxon && !end_on) begin
                fault_run <= 1'b1; // see R8
            end else if (at_limit) begin
                fault_run <= 1'b1; // see R6
            end else if (gate_drive_output && end_on && !fault_out) begin
                fault_run <= 1'b0; // see R7
                fault_cnt <= {CW{1'b0}};
            end
            if (state == `FPS_ST_REC)
                rec_cnt <= rec_cnt + 1'b1;
            else
                rec_cnt <= {CW{1'b0}};
            // Oscillator starts each period; pulses only while running
            if (!running || next_state != state && !(state == `FPS_ST_SOFT
                && next_state == `FPS_ST_RUN)) begin
                gate_drive_output <= 1'b0;
                leb_cnt <= {CW{1'b0}};
            end else if (gate_drive_output) begin
                if (end_on || s_maxon)
                    gate_drive_output <= 1'b0; // see R4, R8
                if (leb_cnt < LEB_CYC)
                    leb_cnt <= leb_cnt + 1'b1; // see R3
            end else if (osc_pulse) begin
                gate_drive_output <= 1'b1;
                leb_cnt <= {CW{1'b0}};
            end
        end
    end

    // Peak detector: sample then reset on detector events
    reg [1:0] quiet_cnt;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            peak_value <= 3'h0;
            peak_valid <= 1'b0;
            peak_reset <= 1'b0;
            quiet_cnt <= 2'h0;
            slope_enable <= 1'b0;
            slope_fast <= 1'b0;
            boosted_thermistor_bias <= 1'b0;
            opc_enable <= 1'b0;
            startup_source_en <= 1'b1;
            internal_supply_en <= 1'b1;
            latched_off <= 1'b0;
            fault_active <= 1'b0;
        end else begin
            peak_reset <= peak_sample_evt; // see R21
            if (s_ledge || s_lfall) begin
                quiet_cnt <= 2'h0;
                peak_valid <= 1'b0;
            end else if (peak_sample_evt) begin
                if (quiet_cnt >= `FPS_PEAK_QUIET - 1) begin
                    peak_value <= peak_code; // see R21, R22
                    peak_valid <= 1'b1;
                end
                if (quiet_cnt < `FPS_PEAK_QUIET - 1)
                    quiet_cnt <= quiet_cnt + 1'b1; // see R22
            end
            slope_enable <= gate_drive_output; // see R19
            slope_fast <= (FAST_VARIANT != 0); // see R19
            boosted_thermistor_bias <= (state == `FPS_ST_SOFT); // see R18
            opc_enable <= running && s_opc; // see R20
            if (tsd_done)
                startup_source_en <= 1'b0; // see R11
            // Re-armed in any stopped state, so an idle trip cannot stick
            else if (!s_tsd && !running)
                startup_source_en <= 1'b1;
            if (off_done)
                internal_supply_en <= 1'b0; // see R12
            else if (state == `FPS_ST_IDLE)
                internal_supply_en <= 1'b1;
            latched_off <= (state == `FPS_ST_LATCH) || hard_latch;
            fault_active <= fault_run;
        end
    end
endmodule

// file: common/fps_consts.vh
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH
`define FPS_CLK_MHZ 20
`define FPS_LEB_NS 250
`define FPS_LEB_CYC ((`FPS_LEB_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_SUPPLY_FILT_US 10
`define FPS_SUPPLY_FILT_CYC (`FPS_SUPPLY_FILT_US * `FPS_CLK_MHZ)
`define FPS_EXT_FILT_SLOW_US 55
`define FPS_EXT_FILT_FAST_US 35
`define FPS_EXT_FILT_SLOW_CYC (`FPS_EXT_FILT_SLOW_US * `FPS_CLK_MHZ)
`define FPS_EXT_FILT_FAST_CYC (`FPS_EXT_FILT_FAST_US * `FPS_CLK_MHZ)
`define FPS_LATCH_HI_US 50
`define FPS_LATCH_LO_US 350
`define FPS_LATCH_HI_CYC (`FPS_LATCH_HI_US * `FPS_CLK_MHZ)
`define FPS_LATCH_LO_CYC (`FPS_LATCH_LO_US * `FPS_CLK_MHZ)
`define FPS_OFF_MS 150
`define FPS_OFF_CYC (`FPS_OFF_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_SS_MS 10
`define FPS_SS_CYC (`FPS_SS_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_SS_STEPS 15
`define FPS_FAULT_MS 128
`define FPS_FAULT_CYC (`FPS_FAULT_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_AUTOREC_MS 1000
`define FPS_AUTOREC_CYC (`FPS_AUTOREC_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_PEAK_BITS 3
`define FPS_PEAK_QUIET 2
`define FPS_ST_IDLE 3'h0
`define FPS_ST_SOFT 3'h1
`define FPS_ST_RUN 3'h2
`define FPS_ST_LATCH 3'h3
`define FPS_ST_REC 3'h4
`define FPS_ST_STOP 3'h5
`endif

// file: src/fps_filter.v
`timescale 1ns/1ns
`include "fps_consts.vh"
module fps_filter #(
    parameter WIDTH = 24
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire clear,
    input wire level,
    input wire [WIDTH-1:0] limit,
    output reg done
);
    reg [WIDTH-1:0] count;
    always @(posedge ref_clk) begin
        if (sys_rst || clear || !level) begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end else if (count >= limit - 1'b1) begin
            done <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule

// file: bench/fps_seq_sva.sv
`timescale 1ns/1ns
module fps_seq_sva (
    input wire ref_clk,
    input wire sys_rst,
    input wire gate_drive_output,
    input wire slope_enable,
    input wire [3:0] setpoint_step,
    input wire winding_short_trip,
    input wire boosted_thermistor_bias,
    input wire latched_off,
    input wire fault_active,
    input wire feedback_above_opc,
    input wire opc_enable,
    input wire peak_sample_evt,
    input wire peak_reset,
    input wire peak_valid,
    input wire line_edge,
    input wire internal_supply_en,
    input wire startup_source_en
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Protection stops may cut a pulse short, so only plain ends are held
    // Latch flags follow the cut by one cycle, so look one cycle later
    property p_leb;
        $fell(gate_drive_output) && !fault_active ##1 !latched_off
            && internal_supply_en && startup_source_en
            |-> $past(gate_drive_output, 7);
    endproperty
    a_leb: assert property (p_leb) else $error("pulse inside blank");
    property p_step;
        $changed(setpoint_step) |-> setpoint_step == 4'h0
            || setpoint_step == $past(setpoint_step) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("step jump");
    property p_latch;
        latched_off && $past(latched_off)
            |-> !gate_drive_output && !boosted_thermistor_bias;
    endproperty
    a_latch: assert property (p_latch) else $error("run latched");
    property p_short;
        $rose(winding_short_trip) && gate_drive_output |-> ##[2:10] latched_off;
    endproperty
    a_short: assert property (p_short) else $error("short missed");
    property p_opc;
        !feedback_above_opc [*4] |=> !opc_enable;
    endproperty
    a_opc: assert property (p_opc) else $error("opc on");
    property p_peak_rst;
        peak_sample_evt |=> peak_reset;
    endproperty
    a_peak_rst: assert property (p_peak_rst) else $error("no reset");
    property p_peak_val;
        $rose(peak_valid) |-> !$past(line_edge, 4);
    endproperty
    a_peak_val: assert property (p_peak_val) else $error("valid");
    property p_off;
        !internal_supply_en || !startup_source_en |-> !gate_drive_output;
    endproperty
    a_off: assert property (p_off) else $error("drive while off");
    property p_slope;
        slope_enable == $past(gate_drive_output);
    endproperty
    a_slope: assert property (p_slope) else $error("slope off");
    c_pulse: cover property ($rose(gate_drive_output));
    c_latch: cover property ($rose(latched_off));
    c_valid: cover property ($rose(peak_valid));
    c_opc: cover property ($rose(opc_enable));
endmodule

bind fps_sequencer fps_seq_sva sva_u (.*);

// file: bench/fps_front_model.sv
`timescale 1ns/1ns
module fps_front_model #(
    parameter logic [7:0] MAX_ON = 8'h1e
) (
    input wire ref_clk,
    input wire gate_drive_output,
    input wire [3:0] setpoint_step,
    input wire [7:0] on_len,
    input wire overload,
    output logic feedback_trip,
    output logic soft_start_trip,
    output logic limit_trip,
    output logic max_on_time
);
    logic [7:0] ramp = 8'h00;
    // Sense current is zero while the switch is off, so all trips drop
    always @(negedge ref_clk) begin
        ramp <= gate_drive_output ? ramp + 8'h01 : 8'h00;
    end
    assign feedback_trip = gate_drive_output && !overload && ramp >= on_len;
    assign limit_trip = gate_drive_output && overload && ramp >= on_len;
    assign soft_start_trip = gate_drive_output
        && ramp >= {2'h0, setpoint_step, 2'h0};
    assign max_on_time = gate_drive_output && ramp >= MAX_ON;
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 1'h0, sys_rst = 1'h1, osc_pulse = 1'h0;
    logic supply_on = 1'h0, supply_reset = 1'h0, line_ok = 1'h1;
    logic winding_short_trip = 1'h0, feedback_above_on = 1'h1;
    logic feedback_above_opc = 1'h0, latch_pin_low = 1'h0;
    logic peak_sample_evt = 1'h0, line_edge = 1'h0, line_fall = 1'h0;
    logic overload = 1'h0, rnd_on = 1'h0;
    logic [2:0] peak_code = 3'h0, peak_value;
    logic [3:0] setpoint_step;
    logic [5:0] flt = 6'h00;
    logic [7:0] on_len = 8'h19;
    logic [8:0] fe = 9'h17a;
    logic [31:0] q, p;
    logic feedback_trip, soft_start_trip, limit_trip, max_on_time;
    logic gate_drive_output, slope_enable, slope_fast, opc_enable;
    logic boosted_thermistor_bias, peak_valid, peak_reset, fault_active;
    logic startup_source_en, internal_supply_en, latched_off;
    wire supply_over = flt[0];
    wire external_latch = flt[1];
    wire supply_under_off = flt[2];
    wire thermal_shutdown = flt[3];
    wire feedback_below_off = flt[4];
    wire latch_pin_high = flt[5];
    integer seed = 64799, mismatches = 0, compares = 0, cc = 0, w, i, t0;
    integer fk[9] = '{0, 0, 1, 1, 2, 3, 4, 5, 5};
    integer fn[9] = '{150, 240, 1000, 1200, 240, 240, 250, 900, 1100};
    fps_sequencer #(.SS_CYCLES(300), .FAULT_CYCLES(200), .AUTOREC_CYCLES(200),
        .OFF_CYCLES(200), .LATCH_LO_CYCLES(50)) dut_u (.*);
    fps_front_model front_u (.*);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        q = $random(seed);
        cc <= cc + 1;
        osc_pulse <= (cc % 40 == 0);
        if (cc % 40 == 0) feedback_above_opc <= q[0];
        if (cc % 40 == 0 && rnd_on) on_len <= 8'h08 + {4'h0, q[4:1]};
    end
    function integer exp_step(input integer t);
        exp_step = t * 15 / 300;
    endfunction
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task pulse_w(output integer n);
        integer k;
        n = 0;
        for (k = 0; k < 100 && gate_drive_output === 1'h1; k++) cyc(1);
        for (k = 0; k < 3000 && gate_drive_output !== 1'h1; k++) cyc(1);
        while (gate_drive_output === 1'h1 && n < 100) begin
            n++;
            cyc(1);
        end
    endtask
    task run_up;
        pulse_w(w);
        cyc(320);
    endtask
    task rel(input logic b);
        if (b) line_ok <= 1'h0;
        else supply_reset <= 1'h1;
        cyc(5);
        line_ok <= 1'h1;
        supply_reset <= 1'h0;
        cyc(5);
    endtask
    task tryf(input integer k, input integer n, input logic e);
        logic stop;
        run_up;
        flt[k] <= 1'h1;
        cyc(n);
        stop = latched_off | ~startup_source_en | ~internal_supply_en;
        chk(stop === e, "fault row");
        flt <= 6'h00;
        rel(1'h0);
    endtask
    task results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(8);
        sys_rst <= 1'h0;
        chk(gate_drive_output === 1'h0 && setpoint_step === 4'h0, "reset");
        {line_fall, line_edge} <= 2'h3;
        cyc(2);
        {line_fall, line_edge} <= 2'h0;
        for (i = 0; i < 3; i++) begin
            p = $random(seed);
            peak_code <= p[2:0];
            cyc(30);
            peak_sample_evt <= 1'h1;
            cyc(1);
            peak_sample_evt <= 1'h0;
            cyc(4);
            // The first sample after an edge is not accepted yet
            chk(peak_value === (i == 0 ? 3'h0 : p[2:0]), "peak code");
            if (i == 0) chk(peak_valid === 1'h0, "early valid");
        end
        chk(peak_valid === 1'h1, "no valid");
        flt[5] <= 1'h1;
        cyc(300);
        flt[5] <= 1'h0;
        chk(latched_off === 1'h0, "early high");
        latch_pin_low <= 1'h1;
        supply_on <= 1'h1;
        for (i = 0; i < 50 && boosted_thermistor_bias !== 1'h1; i++) cyc(1);
        t0 = cc;
        pulse_w(w);
        chk(w >= 5 && w <= 12, "soft pulse");
        cyc(150 - (cc - t0));
        chk(setpoint_step + 1 >= exp_step(cc - t0), "step low");
        chk(setpoint_step <= exp_step(cc - t0) + 1, "step high");
        chk(boosted_thermistor_bias === 1'h1, "no boost");
        cyc(100);
        latch_pin_low <= 1'h0;
        cyc(80);
        chk(setpoint_step === 4'hf, "step end");
        chk(!boosted_thermistor_bias && !latched_off, "ss end");
        chk(slope_fast === 1'h0, "slope rate");
        on_len <= 8'h02;
        pulse_w(w);
        chk(w >= 5 && w <= 9, "blank");
        on_len <= 8'h14;
        pulse_w(w);
        chk(w >= 20 && w <= 26, "fb end");
        latch_pin_low <= 1'h1;
        cyc(40);
        latch_pin_low <= 1'h0;
        cyc(10);
        chk(latched_off === 1'h0, "short low");
        latch_pin_low <= 1'h1;
        cyc(90);
        latch_pin_low <= 1'h0;
        cyc(300);
        chk(latched_off === 1'h1, "low latch");
        rel(1'h0);
        chk(latched_off === 1'h0, "reset release");
        run_up;
        rnd_on <= 1'h1;
        repeat (3) begin
            overload <= 1'h1;
            cyc(100);
            chk(fault_active === 1'h1, "timer idle");
            overload <= 1'h0;
            cyc(100);
            chk(fault_active === 1'h0, "timer left");
        end
        chk(latched_off === 1'h0, "timer kept");
        overload <= 1'h1;
        cyc(300);
        overload <= 1'h0;
        chk(latched_off === 1'h1, "overload");
        rel(1'h1);
        chk(latched_off === 1'h0, "brown-out release");
        run_up;
        rnd_on <= 1'h0;
        cyc(1);
        on_len <= 8'hff;
        cyc(300);
        chk(latched_off === 1'h1, "max on");
        on_len <= 8'h19;
        rel(1'h0);
        run_up;
        for (i = 0; i < 100 && gate_drive_output !== 1'h1; i++) cyc(1);
        cyc(8);
        winding_short_trip <= 1'h1;
        cyc(3);
        winding_short_trip <= 1'h0;
        cyc(6);
        chk(latched_off === 1'h1, "short");
        rel(1'h0);
        rnd_on <= 1'h1;
        for (i = 0; i < 9; i++) tryf(fk[i], fn[i], fe[i]);
        results;
    end
    // Roughly three times the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        results;
    end
endmodule
